// ---- rtl/cpu_instruction_timing.sv ----
// Clock-exact instruction sequencer of the pipelined 8-bit core
//
// Operation
// [RULE1] Decode every classic opcode identically
// [RULE2] Sequence purely in single system clocks
// [RULE3] Most instructions: clocks equal program bytes
// [RULE4] Untaken conditional branch finishes one clock sooner
// [RULE5] No instruction exceeds eight clocks
// [RULE6] 109 instructions; 26 one-clock, 50 two-clock
// [RULE7] Runs zero to 25 MHz, one per clock
// [RULE8] Add indirect RAM: one byte, two clocks
// [RULE9] Add immediate with carry: two bytes, two clocks
// [RULE10] Subtract indirect with borrow: one byte, two clocks
// [RULE11] AND immediate into direct: three bytes, three clocks
// [RULE12] AND accumulator into direct: two bytes, two clocks
// [RULE13] XOR bank register into accumulator: one clock
// [RULE14] External move reaches on-chip, off-chip, flash
// [RULE15] Software reads and modifies flash bytewise
// [RULE16] Debug breakpoints, watchpoints, start, stop, step
// [RULE17] Count from opcode fetch to next fetch
`timescale 1ns/1ns
module cpu_instruction_timing (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire logic [7:0] i_code_data,
	input wire logic i_branch_taken,
	input wire logic [15:0] i_branch_target,
	input wire logic i_xdm_flash_sel,
	input wire logic i_xdm_offchip_sel,
	input wire logic [15:0] i_xdm_addr,
	input wire cpu_timing_pkg::dbg_pins_t i_dbg_pins,
	input wire logic i_bkpt_en,
	input wire logic [15:0] i_bkpt_addr,
	input wire logic i_watch_en,
	input wire logic [15:0] i_watch_addr,
	input wire logic i_data_valid,
	input wire logic [15:0] i_data_addr,
	output logic [15:0] o_code_addr,
	output logic o_opcode_fetch,
	output logic [7:0] o_opcode,
	output logic [2:0] o_cycle_idx,
	output logic o_instr_done,
	output cpu_timing_pkg::instr_timing_t o_timing,
	output cpu_timing_pkg::xdm_req_t o_xdm,
	output logic o_code_byte_rd,
	output logic o_halted
);

	cpu_timing_pkg::run_state_t st_r;
	cpu_timing_pkg::run_state_t st_nxt;
	cpu_timing_pkg::instr_timing_t tim_r;
	cpu_timing_pkg::instr_timing_t lut_w;
	cpu_timing_pkg::instr_timing_t cur_w;
	cpu_timing_pkg::xdm_req_t xdm_r;
	cpu_timing_pkg::xdm_req_t xdm_nxt;
	cpu_timing_pkg::xdm_target_t xdm_tgt_w;
	logic [15:0] pc_r;
	logic [15:0] pc_nxt;
	logic [2:0] cyc_r;
	logic [2:0] cyc_nxt;
	logic [7:0] op_r;
	logic [7:0] op_nxt;
	logic fetch_r;
	logic fetch_nxt;
	logic ext_r;
	logic done_r;
	logic code_rd_r;
	logic halted_r;
	logic running_w;
	logic base_last_w;
	logic taken_w;
	logic extend_w;
	logic end_w;
	logic byte_w;
	logic boundary_w;
	logic stop_w;
	logic resume_w;

	// ==========================================
	// Opcode decode and debug control
	// Full opcode map, lengths and clocks per opcode [RULE1] [RULE6]
	cycle_lut u_cycle_lut (
		.i_opcode(i_code_data),
		.o_timing(lut_w)
	);

	debug_ctl u_debug_ctl (
		.i_sys_clk(i_sys_clk),
		.i_rstn(i_rstn),
		.i_pins(i_dbg_pins),
		.i_halted(halted_r),
		.i_boundary(boundary_w),
		.i_next_pc(pc_nxt),
		.i_bkpt_en(i_bkpt_en),
		.i_bkpt_addr(i_bkpt_addr),
		.i_watch_en(i_watch_en),
		.i_watch_addr(i_watch_addr),
		.i_data_valid(i_data_valid),
		.i_data_addr(i_data_addr),
		.o_stop(stop_w),
		.o_resume(resume_w)
	);

	// ==========================================
	// Cycle sequencing
	// Timing comes from the lookup in the fetch clock, latched after
	assign cur_w = fetch_r ? lut_w : tim_r;
	assign running_w = (st_r == cpu_timing_pkg::ST_RUN);
	// Plain clock counting, no machine-cycle grouping [RULE2] [RULE17]
	assign base_last_w = running_w && ({1'b0, cyc_r} == (cur_w.cycles - cpu_timing_pkg::CYCLES_ONE));
	assign taken_w = base_last_w && i_branch_taken;
	// Taken conditional branch adds one clock [RULE4]
	assign extend_w = taken_w && cur_w.cond;
	assign end_w = (base_last_w && !extend_w) || ext_r;
	assign boundary_w = running_w && end_w;
	// One program byte fetched per clock while bytes remain [RULE3]
	assign byte_w = running_w && ({1'b0, cyc_r} < {2'b00, cur_w.len});
	assign pc_nxt = taken_w ? i_branch_target : (byte_w ? pc_r + cpu_timing_pkg::PC_STEP : pc_r);
	// Next opcode fetch follows the last clock directly [RULE7]
	assign cyc_nxt = (end_w || !running_w) ? cpu_timing_pkg::CYC_RESET : cyc_r + 3'd1;
	assign st_nxt = (running_w && end_w && stop_w) ? cpu_timing_pkg::ST_HALT :
		(!running_w && resume_w) ? cpu_timing_pkg::ST_RUN : st_r;
	assign fetch_nxt = (st_nxt == cpu_timing_pkg::ST_RUN) && (cyc_nxt == cpu_timing_pkg::CYC_RESET);
	assign op_nxt = fetch_r ? i_code_data : op_r;

	// ==========================================
	// External data move and code byte read
	// Target chosen by configuration and address [RULE14]
	assign xdm_tgt_w = i_xdm_flash_sel ? cpu_timing_pkg::XDM_FLASH :
		(i_xdm_offchip_sel && (i_xdm_addr >= cpu_timing_pkg::EXPANDED_DATA_RAM_ONCHIP_BYTES)) ?
		cpu_timing_pkg::XDM_OFFCHIP : cpu_timing_pkg::XDM_ONCHIP;
	// Flash byte read or write through the external move [RULE15]
	assign xdm_nxt.strobe = fetch_r && lut_w.xdm;
	assign xdm_nxt.write = (fetch_r && lut_w.xdm) ? i_code_data[cpu_timing_pkg::XDM_WR_BIT] : xdm_r.write;
	assign xdm_nxt.target = (fetch_r && lut_w.xdm) ? xdm_tgt_w : xdm_r.target;

	// ==========================================
	// Registers
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			st_r <= cpu_timing_pkg::ST_RUN;
			pc_r <= cpu_timing_pkg::PC_RESET;
			cyc_r <= cpu_timing_pkg::CYC_RESET;
			fetch_r <= 1'b1;
			ext_r <= 1'b0;
			tim_r <= cpu_timing_pkg::TIMING_RESET;
			op_r <= 8'h00;
			done_r <= 1'b0;
			halted_r <= 1'b0;
			xdm_r <= cpu_timing_pkg::XDM_RESET;
			code_rd_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			pc_r <= pc_nxt;
			cyc_r <= cyc_nxt;
			fetch_r <= fetch_nxt;
			ext_r <= extend_w;
			tim_r <= cur_w;
			op_r <= op_nxt;
			done_r <= boundary_w;
			halted_r <= (st_nxt == cpu_timing_pkg::ST_HALT);
			xdm_r <= xdm_nxt;
			code_rd_r <= fetch_r && lut_w.code_rd; // [RULE15]
		end
	end

	assign o_code_addr = pc_r;
	assign o_opcode_fetch = fetch_r;
	assign o_opcode = op_r;
	assign o_cycle_idx = cyc_r;
	assign o_instr_done = done_r;
	assign o_timing = tim_r;
	assign o_xdm = xdm_r;
	assign o_code_byte_rd = code_rd_r;
	assign o_halted = halted_r;

	// ==========================================
	// Checks
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rstn);

	sequence s_next_fetch;
		fetch_r || halted_r;
	endsequence

	sequence s_two_clocks;
		!fetch_r ##1 s_next_fetch;
	endsequence

	sequence s_three_clocks;
		!fetch_r [*2] ##1 s_next_fetch;
	endsequence

	property p_xrl_bank_one;
		fetch_r && (i_code_data >= cpu_timing_pkg::OP_XRL_BANK_LO)
			&& (i_code_data <= cpu_timing_pkg::OP_XRL_BANK_HI)
			|=> s_next_fetch and (o_code_addr == $past(o_code_addr) + 16'd1);
	endproperty
	a_xrl_bank_one: assert property (p_xrl_bank_one) else $error("xor bank not one clock"); // [RULE13]

	property p_add_ind_two;
		fetch_r && ((i_code_data == cpu_timing_pkg::OP_ADD_IND0)
			|| (i_code_data == cpu_timing_pkg::OP_ADD_IND1)) && !i_branch_taken
			|=> s_two_clocks ##0 (o_code_addr == $past(o_code_addr, 2) + 16'd1);
	endproperty
	a_add_ind_two: assert property (p_add_ind_two) else $error("add indirect timing wrong"); // [RULE8]

	property p_addc_imm_two;
		fetch_r && (i_code_data == cpu_timing_pkg::OP_ADDC_IMM) && !i_branch_taken
			|=> s_two_clocks ##0 (o_code_addr == $past(o_code_addr, 2) + 16'd2);
	endproperty
	a_addc_imm_two: assert property (p_addc_imm_two) else $error("addc immediate timing wrong"); // [RULE9]

	property p_subb_ind_two;
		fetch_r && ((i_code_data == cpu_timing_pkg::OP_SUBB_IND0)
			|| (i_code_data == cpu_timing_pkg::OP_SUBB_IND1))
			|=> s_two_clocks;
	endproperty
	a_subb_ind_two: assert property (p_subb_ind_two) else $error("subb indirect not two clocks"); // [RULE10]

	property p_anl_dir_imm_three;
		fetch_r && (i_code_data == cpu_timing_pkg::OP_ANL_DIR_IMM) && !i_branch_taken
			|=> s_three_clocks ##0 (o_code_addr == $past(o_code_addr, 3) + 16'd3);
	endproperty
	a_anl_dir_imm_three: assert property (p_anl_dir_imm_three) else $error("anl dir imm timing"); // [RULE11]

	property p_anl_dir_a_two;
		fetch_r && (i_code_data == cpu_timing_pkg::OP_ANL_DIR_A) |=> s_two_clocks;
	endproperty
	a_anl_dir_a_two: assert property (p_anl_dir_a_two) else $error("anl dir acc not two clocks"); // [RULE12]

	property p_cond_taken_extra;
		base_last_w && cur_w.cond && i_branch_taken |=> !fetch_r ##1 s_next_fetch;
	endproperty
	a_cond_taken_extra: assert property (p_cond_taken_extra) else $error("taken branch not extended"); // [RULE4]

	property p_cond_untaken_ends;
		base_last_w && cur_w.cond && !i_branch_taken |=> s_next_fetch;
	endproperty
	a_cond_untaken_ends: assert property (p_cond_untaken_ends) else $error("untaken branch too long"); // [RULE4]

	property p_eight_clock_bound;
		fetch_r |=> ##[0:7] s_next_fetch;
	endproperty
	a_eight_clock_bound: assert property (p_eight_clock_bound) else $error("instruction over eight clocks"); // [RULE5]

	property p_halt_freezes;
		halted_r |-> !fetch_r ##1 $stable(o_code_addr);
	endproperty
	a_halt_freezes: assert property (p_halt_freezes) else $error("fetch while halted"); // [RULE16]

	property p_flash_target;
		fetch_r && lut_w.xdm && i_xdm_flash_sel
			|=> o_xdm.strobe && (o_xdm.target == cpu_timing_pkg::XDM_FLASH);
	endproperty
	a_flash_target: assert property (p_flash_target) else $error("external move missed flash"); // [RULE14]

	property p_one_clock_op;
		fetch_r && (lut_w.cycles == cpu_timing_pkg::CYCLES_ONE) |=> s_next_fetch;
	endproperty
	a_one_clock_op: assert property (p_one_clock_op) else $error("one clock op stalled"); // [RULE7]

	property p_fetch_index_zero;
		o_opcode_fetch |-> (o_cycle_idx == cpu_timing_pkg::CYC_RESET);
	endproperty
	a_fetch_index_zero: assert property (p_fetch_index_zero) else $error("fetch off index zero"); // [RULE17]

	property p_done_then_fetch;
		o_instr_done |-> s_next_fetch;
	endproperty
	a_done_then_fetch: assert property (p_done_then_fetch) else $error("done without fetch"); // [RULE17]

	property p_code_rd_pulse;
		fetch_r && lut_w.code_rd |=> o_code_byte_rd ##1 !o_code_byte_rd;
	endproperty
	a_code_rd_pulse: assert property (p_code_rd_pulse) else $error("code byte read pulse"); // [RULE15]

	property p_xdm_write_dir;
		fetch_r && lut_w.xdm
			|=> o_xdm.strobe && (o_xdm.write == o_opcode[cpu_timing_pkg::XDM_WR_BIT]);
	endproperty
	a_xdm_write_dir: assert property (p_xdm_write_dir) else $error("external move direction"); // [RULE15]

	property p_offchip_target;
		fetch_r && lut_w.xdm && !i_xdm_flash_sel && i_xdm_offchip_sel
			&& (i_xdm_addr >= cpu_timing_pkg::EXPANDED_DATA_RAM_ONCHIP_BYTES)
			|=> o_xdm.target == cpu_timing_pkg::XDM_OFFCHIP;
	endproperty
	a_offchip_target: assert property (p_offchip_target) else $error("missed off-chip ram"); // [RULE14]

	property p_onchip_target;
		fetch_r && lut_w.xdm && !i_xdm_flash_sel
			&& (!i_xdm_offchip_sel || (i_xdm_addr < cpu_timing_pkg::EXPANDED_DATA_RAM_ONCHIP_BYTES))
			|=> o_xdm.target == cpu_timing_pkg::XDM_ONCHIP;
	endproperty
	a_onchip_target: assert property (p_onchip_target) else $error("missed on-chip ram"); // [RULE14]

	property p_resume_fetches;
		$fell(halted_r) |-> fetch_r;
	endproperty
	a_resume_fetches: assert property (p_resume_fetches) else $error("resume without fetch"); // [RULE16]

endmodule

// ---- rtl/cpu_timing_pkg.sv ----
// Shared constants and types for the instruction timing sequencer
package cpu_timing_pkg;

	// ==========================================
	// Reset values and limits
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [15:0] EXPANDED_DATA_RAM_ONCHIP_BYTES = 16'h1000;
	localparam logic [2:0] CYC_RESET = 3'h0;
	localparam logic [3:0] CYCLES_ONE = 4'h1;
	localparam logic [15:0] PC_STEP = 16'h0001;
	localparam int unsigned XDM_WR_BIT = 4;
	localparam int unsigned MAX_CLOCK_MHZ = 25;

	// ==========================================
	// Opcodes watched by the checks
	localparam logic [7:0] OP_ADD_IND0 = 8'h26;
	localparam logic [7:0] OP_ADD_IND1 = 8'h27;
	localparam logic [7:0] OP_ADDC_IMM = 8'h34;
	localparam logic [7:0] OP_SUBB_IND0 = 8'h96;
	localparam logic [7:0] OP_SUBB_IND1 = 8'h97;
	localparam logic [7:0] OP_ANL_DIR_A = 8'h52;
	localparam logic [7:0] OP_ANL_DIR_IMM = 8'h53;
	localparam logic [7:0] OP_XRL_BANK_LO = 8'h68;
	localparam logic [7:0] OP_XRL_BANK_HI = 8'h6f;

	// ==========================================
	// Types
	typedef struct packed {
		logic [1:0] len;
		logic [3:0] cycles;
		logic cond;
		logic xdm;
		logic code_rd;
	} instr_timing_t;

	localparam instr_timing_t TIMING_RESET = '0;

	typedef enum logic [1:0] {
		XDM_ONCHIP = 2'b00,
		XDM_OFFCHIP = 2'b01,
		XDM_FLASH = 2'b10
	} xdm_target_t;

	typedef struct packed {
		logic strobe;
		logic write;
		xdm_target_t target;
	} xdm_req_t;

	localparam xdm_req_t XDM_RESET = '0;

	typedef struct packed {
		logic halt;
		logic run;
		logic step;
	} dbg_pins_t;

	typedef enum logic {
		ST_RUN = 1'b0,
		ST_HALT = 1'b1
	} run_state_t;

endpackage

// ---- rtl/cycle_lut.sv ----
// Opcode to length and clock count decoder
`timescale 1ns/1ns
module cycle_lut (
	input wire logic [7:0] i_opcode,
	output cpu_timing_pkg::instr_timing_t o_timing
);

	cpu_timing_pkg::instr_timing_t t;
	logic [1:0] len;
	logic [3:0] cyc;
	logic cond;

	// ==========================================
	// Length, base clocks, conditional flag
	always_comb
	begin
		len = 2'd1;
		cyc = 4'd1;
		cond = 1'b0;
		casez (i_opcode)
			8'h?1: begin len = 2'd2; cyc = 4'd3; end
			8'h02, 8'h12: begin len = 2'd3; cyc = 4'd4; end
			8'h22, 8'h32: begin len = 2'd1; cyc = 4'd5; end
			8'h10, 8'h20, 8'h30: begin len = 2'd3; cyc = 4'd3; cond = 1'b1; end
			8'h40, 8'h50, 8'h60, 8'h70: begin len = 2'd2; cyc = 4'd2; cond = 1'b1; end
			8'h80: begin len = 2'd2; cyc = 4'd3; end
			8'h90, 8'h43, 8'h53, 8'h63, 8'h75, 8'h85: begin len = 2'd3; cyc = 4'd3; end
			8'ha0, 8'hb0, 8'hc0, 8'hd0: begin len = 2'd2; cyc = 4'd2; end
			8'he0, 8'hf0, 8'he2, 8'hf2, 8'he3, 8'hf3: begin len = 2'd1; cyc = 4'd3; end
			8'h83, 8'h93, 8'h73: begin len = 2'd1; cyc = 4'd3; end
			8'h42, 8'h52, 8'h62, 8'h72, 8'h82: begin len = 2'd2; cyc = 4'd2; end
			8'h92, 8'ha2, 8'hb2, 8'hc2, 8'hd2: begin len = 2'd2; cyc = 4'd2; end
			8'h24, 8'h34, 8'h44, 8'h54, 8'h64, 8'h74, 8'h94: begin len = 2'd2; cyc = 4'd2; end
			8'hb4, 8'hb5, 8'hd5, 8'b10111???: begin len = 2'd3; cyc = 4'd3; cond = 1'b1; end
			8'hb6, 8'hb7: begin len = 2'd3; cyc = 4'd4; cond = 1'b1; end
			8'b11011???: begin len = 2'd2; cyc = 4'd2; cond = 1'b1; end
			8'h84: begin len = 2'd1; cyc = 4'd8; end
			8'ha4: begin len = 2'd1; cyc = 4'd4; end
			8'h76, 8'h77, 8'h86, 8'h87, 8'ha6, 8'ha7: begin len = 2'd2; cyc = 4'd2; end
			8'h?6, 8'h?7: begin len = 2'd1; cyc = 4'd2; end
			8'b01111???, 8'b10001???, 8'b10101???: begin len = 2'd2; cyc = 4'd2; end
			8'ha5: begin len = 2'd1; cyc = 4'd1; end
			8'h?5: begin len = 2'd2; cyc = 4'd2; end
			default: begin len = 2'd1; cyc = 4'd1; end
		endcase
		t.len = len;
		t.cycles = cyc;
		t.cond = cond;
		t.xdm = (i_opcode[7:5] == 3'b111) && (i_opcode[3:2] == 2'b00) && (i_opcode[1:0] != 2'b01);
		t.code_rd = (i_opcode == 8'h83) || (i_opcode == 8'h93);
	end

	assign o_timing = t;

endmodule

// ---- rtl/debug_ctl.sv ----
// Debug halt, run, step, breakpoint and watchpoint control
`timescale 1ns/1ns
module debug_ctl (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire cpu_timing_pkg::dbg_pins_t i_pins,
	input wire logic i_halted,
	input wire logic i_boundary,
	input wire logic [15:0] i_next_pc,
	input wire logic i_bkpt_en,
	input wire logic [15:0] i_bkpt_addr,
	input wire logic i_watch_en,
	input wire logic [15:0] i_watch_addr,
	input wire logic i_data_valid,
	input wire logic [15:0] i_data_addr,
	output logic o_stop,
	output logic o_resume
);

	cpu_timing_pkg::dbg_pins_t meta_r;
	cpu_timing_pkg::dbg_pins_t sync_r;
	cpu_timing_pkg::dbg_pins_t prev_r;
	logic step_armed_r;
	logic step_armed_nxt;
	logic watch_r;
	logic watch_nxt;

	// ==========================================
	// Decode
	wire run_edge = sync_r.run & ~prev_r.run;
	wire step_edge = sync_r.step & ~prev_r.step;
	wire bkpt_hit = i_bkpt_en && (i_next_pc == i_bkpt_addr);
	wire watch_set = i_watch_en && i_data_valid && (i_data_addr == i_watch_addr);
	wire watch_any = watch_r | watch_set;

	// Stop only at an instruction boundary, no memory or timer used [RULE16]
	assign o_stop = i_boundary && (sync_r.halt || step_armed_r || bkpt_hit || watch_any);
	assign o_resume = i_halted && (run_edge || step_edge);
	assign step_armed_nxt = (o_resume && step_edge) ? 1'b1 :
		(o_resume || i_boundary) ? 1'b0 : step_armed_r;
	assign watch_nxt = i_boundary ? 1'b0 : watch_any;

	// ==========================================
	// Registers
	always_ff @(posedge i_sys_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			meta_r <= '0;
			sync_r <= '0;
			prev_r <= '0;
			step_armed_r <= 1'b0;
			watch_r <= 1'b0;
		end
		else
		begin
			meta_r <= i_pins;
			sync_r <= meta_r;
			prev_r <= sync_r;
			step_armed_r <= step_armed_nxt;
			watch_r <= watch_nxt;
		end
	end

endmodule

// ---- sim/cpu_instruction_timing_test.sv ----
// Self-checking bench for the instruction timing sequencer
`timescale 1ns/1ns
module cpu_instruction_timing_test;
	logic i_sys_clk = 0;
	logic i_rstn = 0;
	logic tk = 0;
	logic fsel = 0;
	logic osel = 0;
	logic ben = 0;
	logic wen = 0;
	logic dv = 0;
	logic [15:0] tgt = '0;
	logic [15:0] xa = '0;
	logic [15:0] ba = '0;
	logic [15:0] wa = '0;
	logic [15:0] da = '0;
	cpu_timing_pkg::dbg_pins_t pins = '0;
	logic [15:0] pc;
	logic [7:0] code;
	logic [7:0] op;
	logic [2:0] idx;
	logic fetch;
	logic done;
	logic cbr;
	logic halted;
	cpu_timing_pkg::instr_timing_t tim;
	cpu_timing_pkg::xdm_req_t xdm;
	cpu_timing_pkg::xdm_target_t xt;
	logic [15:0] exp_pc = '0;
	logic xw = 0;
	int fails = 0;
	int n_checks = 0;
	int cnt = 0;
	int exp_cyc = 0;
	int cur = 0;
	bit have, pcv, dp, xp, cp, t, ok;
	int ilen [256];
	int icyc [256];
	bit icnd [256];
	int starts [$];
	// ==========================================
	// Opcode, bytes, base clocks; entries 11 to 13 are conditional branches
	logic [7:0] ops [20] = '{8'h26, 8'h27, 8'h34, 8'h96, 8'h97, 8'h53, 8'h52, 8'h68, 8'h6f,
		8'h84, 8'ha4, 8'h40, 8'h20, 8'hb6, 8'he0, 8'hf0, 8'h93, 8'h83, 8'h00, 8'ha5};
	int lens [20] = '{1, 1, 2, 1, 1, 3, 2, 1, 1, 1, 1, 2, 3, 3, 1, 1, 1, 1, 1, 1};
	int cycs [20] = '{2, 2, 2, 2, 2, 3, 2, 1, 1, 8, 4, 2, 3, 4, 3, 3, 3, 3, 1, 1};

	prog_mem_model pm (.i_addr(pc), .o_data(code));
	cpu_instruction_timing dut (
		.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_code_data(code), .i_branch_taken(tk),
		.i_branch_target(tgt), .i_xdm_flash_sel(fsel), .i_xdm_offchip_sel(osel),
		.i_xdm_addr(xa), .i_dbg_pins(pins), .i_bkpt_en(ben), .i_bkpt_addr(ba),
		.i_watch_en(wen), .i_watch_addr(wa), .i_data_valid(dv), .i_data_addr(da),
		.o_code_addr(pc), .o_opcode_fetch(fetch), .o_opcode(op), .o_cycle_idx(idx),
		.o_instr_done(done), .o_timing(tim), .o_xdm(xdm), .o_code_byte_rd(cbr),
		.o_halted(halted)
	);

	always #5 i_sys_clk = ~i_sys_clk;

	// ==========================================
	// Reporting
	task automatic chk(input bit c, input string m);
		n_checks++;
		if (!c)
		begin
			fails++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask

	task automatic summarize();
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ==========================================
	// Program image with every listed opcode, then random ones
	task automatic build();
		int a;
		int j;
		int k;
		a = 0;
		j = 0;
		k = 0;
		for (int i = 0; i < 256; i++)
		begin
			pm.mem[i] = 8'h00;
			ilen[i] = 1;
			icyc[i] = 1;
			icnd[i] = 0;
		end
		while (a < 240)
		begin
			starts.push_back(a);
			pm.mem[a] = ops[j];
			ilen[a] = lens[j];
			icyc[a] = cycs[j];
			icnd[a] = j >= 11 && j <= 13;
			for (int b = 1; b < lens[j]; b++)
				pm.mem[a + b] = 8'($urandom);
			a += lens[j];
			k++;
			j = (k < 20) ? k : $urandom_range(19);
		end
	endtask

	task automatic waith(input logic v, input int n);
		int i;
		i = 0;
		while (halted !== v && i < n)
		begin
			@(negedge i_sys_clk);
			i++;
		end
		chk(halted === v, "halt state");
	endtask

	task automatic resume(input int b);
		pins[b] = 1'b1;
		waith(1'b0, 12);
		pins[b] = 1'b0;
	endtask

	// ==========================================
	// Reference model and branch driver
	always @(negedge i_sys_clk)
	begin
		t = 0;
		fsel = 1'($urandom);
		osel = 1'($urandom);
		xa = 16'($urandom);
		if (i_rstn && !halted)
		begin
			ok = op === pm.mem[cur] && tim.len === 2'(ilen[cur]) && tim.cond === icnd[cur];
			ok = ok && tim.xdm === xp && tim.code_rd === cp;
			if (dp)
				chk(ok && tim.cycles === 4'(icyc[cur]), "decode");
			ok = !xp || (xdm.target === xt && xdm.write === xw);
			chk(xdm.strobe === xp && ok, "external move");
			chk(cbr === cp, "code byte read");
			if (have || !fetch)
				chk(done === fetch, "done pulse");
			dp = 0;
			xp = 0;
			cp = 0;
			if (fetch)
			begin
				if (have)
					chk(cnt == exp_cyc, "clock count");
				if (pcv)
					chk(pc === exp_pc, "fetch address");
				cur = pc[7:0];
				exp_cyc = icyc[cur];
				exp_pc = pc + 16'(ilen[cur]);
				cnt = 0;
				have = 1;
				pcv = 1;
				dp = 1;
				xp = code inside {8'he0, 8'hf0};
				cp = code inside {8'h83, 8'h93};
				xw = code[cpu_timing_pkg::XDM_WR_BIT];
				if (fsel)
					xt = cpu_timing_pkg::XDM_FLASH;
				else if (osel && xa >= cpu_timing_pkg::EXPANDED_DATA_RAM_ONCHIP_BYTES)
					xt = cpu_timing_pkg::XDM_OFFCHIP;
				else
					xt = cpu_timing_pkg::XDM_ONCHIP;
			end
			else if (icnd[cur] && idx === 3'(icyc[cur] - 1))
			begin
				t = 1'($urandom);
				if (t)
				begin
					tgt = 16'(starts[$urandom_range(starts.size() - 1)]);
					exp_pc = tgt;
					exp_cyc++;
				end
			end
			if (have)
				chk(idx === 3'(cnt), "cycle index");
			cnt++;
		end
		else
			have = 0;
		tk = t;
	end

	// ==========================================
	// Watchdog
	initial
	begin
		#200000;
		fails++;
		summarize();
	end

	// ==========================================
	// Main sequence
	initial
	begin
		void'($urandom(32'h4c9b));
		build();
		repeat (5) @(negedge i_sys_clk);
		i_rstn <= 1'b1;
		repeat (800) @(negedge i_sys_clk);
		wen = 1;
		wa = 16'h0123;
		da = 16'h0124;
		dv = 1;
		@(negedge i_sys_clk);
		dv = 0;
		repeat (12) @(negedge i_sys_clk);
		chk(halted === 1'b0, "stray watch");
		da = wa;
		dv = 1;
		@(negedge i_sys_clk);
		dv = 0;
		waith(1'b1, 12);
		wen = 0;
		resume(1);
		ba = 16'(starts[7]);
		ben = 1;
		waith(1'b1, 8000);
		chk(pc === ba, "breakpoint address");
		ben = 0;
		resume(0);
		waith(1'b1, 20);
		resume(1);
		repeat (30) @(negedge i_sys_clk);
		chk(halted === 1'b0, "keeps running");
		pins.halt = 1;
		waith(1'b1, 20);
		pins.halt = 0;
		repeat (10) @(negedge i_sys_clk);
		chk(halted === 1'b1, "holds halt");
		resume(1);
		repeat (200) @(negedge i_sys_clk);
		summarize();
	end
endmodule

// ---- sim/prog_mem_model.sv ----
// Zero-wait program memory model facing the sequencer
`timescale 1ns/1ns
module prog_mem_model (
	input wire logic [15:0] i_addr,
	output logic [7:0] o_data
);
	// ==========================================
	// Storage, filled by the bench before reset ends
	logic [7:0] mem [256];

	// ==========================================
	// Read path, same clock as the address
	assign o_data = mem[i_addr[7:0]];
endmodule
